// >>> core/tmr_core.sv
// Behaviour
// R1: writing a compare shadow sets its valid flag; update clears it
// R2: writing the limit shadow sets its valid flag; update clears it
// R3: writing one to the flag-set register sets valid bits; zero leaves them
// R4: action 0 counts rising event edges; action 1 counts both edges
// R5: action 2 counts prescaled ticks while event is high
// R6: action 3 counts up while event low, down while high
// R7: up/down direction sampled only when a count step happens
// R8: event enable zero ignores events; one follows the action code
// R9: each compare channel interrupt gated by its own enable bit
// R10: overflow interrupt gated by its enable bit
// R11: compare flag set whenever counter equals active compare value; code sets it only while running (not halted with run bit zero)
// R12: compare flag stays until software writes one to it
// R13: overflow flag set at top or bottom per waveform mode
// R14: overflow flag clears only by writing one
// R15: halted with run bit zero: counter stops, events ignored
// R16: halted with run bit one: counter runs normally
// R17: one shared staging byte for 16-bit access, software readable/writable
// R18: 16-bit registers: low byte at offset, high byte at offset plus one
// R19: top limit sets counting limit except frequency mode; resets all ones
// R20: lock blocks update-condition transfer; software update command still transfers
// R21: update copies compare shadows into active compares
// R22: normal/frequency update at top counting up; single-slope updates at bottom
// R23: low byte write staged, high byte write commits; low read captures high
// R24: each interrupt request is flag AND enable, held while both set
//
// Purpose: 16-bit timer counter, event counting, flags and register port
// Assumes: evt_in and dbg_halt come from other domains; tick_en is a prescaler pulse
// Notes: waveform, lock and command bits sit at chosen offsets 0x00 and 0x05
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "tmr_defines.svh"
module tmr_core #(
  parameter int NCMP = 3
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic tick_en,
  input wire logic evt_in,
  input wire logic dbg_halt,
  output logic irq_ovf,
  output logic [NCMP-1:0] irq_cmp,
  output logic [NCMP-1:0] cmp_match
);
  logic [15:0] cnt_q;
  logic [15:0] top_q;
  logic [15:0] limsh_q;
  logic [15:0] cmp_q [NCMP];
  logic [15:0] cmpsh_q [NCMP];
  logic [NCMP:0] valid_q;
  logic [7:0] event_control_q;
  logic [7:0] inten_q;
  logic [7:0] stage_q;
  logic [7:0] rdata_q;
  logic [NCMP:0] flag_q;
  logic run_halt_q;
  logic lock_q;
  logic dir_q;
  logic [2:0] wave_q;
  logic [1:0] evt_sync_q;
  logic [1:0] halt_sync_q;
  logic evt_prev_q;

  // two flops before any logic sees outside levels
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
    begin
      evt_sync_q <= 2'h0;
      halt_sync_q <= 2'h0;
      evt_prev_q <= 1'b0;
    end
    else
    begin
      evt_sync_q <= {evt_sync_q[0], evt_in};
      halt_sync_q <= {halt_sync_q[0], dbg_halt};
      evt_prev_q <= evt_sync_q[1];
    end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
    hit = (a == base);
  endfunction

  // high byte of a 16-bit pair commits the whole word
  function automatic logic hit_hi(input logic [7:0] a, input logic [7:0] base);
    hit_hi = (a == base + 8'h01);
  endfunction

  // register selects shared by the write paths
  wire sel_vfset = hit(reg_addr, `TMR_OFS_VFSET);
  wire sel_vfclr = hit(reg_addr, `TMR_OFS_VFCLR);
  wire sel_event_control = hit(reg_addr, `TMR_OFS_EVENT_CONTROL);
  wire sel_inten = hit(reg_addr, `TMR_OFS_INTEN);
  wire sel_intflg = hit(reg_addr, `TMR_OFS_INTFLG);
  wire sel_dbg = hit(reg_addr, `TMR_OFS_DBG);
  wire sel_stage = hit(reg_addr, `TMR_OFS_STAGE);
  wire sel_wave = hit(reg_addr, `TMR_OFS_WAVE);
  wire sel_cmd = hit(reg_addr, `TMR_OFS_CMD);
  wire sel_cnt_hi = hit_hi(reg_addr, `TMR_OFS_CNT);
  wire sel_top_hi = hit_hi(reg_addr, `TMR_OFS_TOP);
  wire sel_limsh_hi = hit_hi(reg_addr, `TMR_OFS_LIMSH);

  wire evt = evt_sync_q[1];
  wire halted = halt_sync_q[1];
  wire running = !halted || run_halt_q; // [R15] [R16]
  wire ev_en = event_control_q[`TMR_BIT_EV_EN] && running; // [R8] [R15]
  wire [2:0] event_action_select = event_control_q[`TMR_BIT_EVENT_ACTION_SELECT_LO +: 3];
  wire rise = evt && !evt_prev_q;
  wire fall = !evt && evt_prev_q;
  wire wr_hi = reg_wr && reg_addr[0];

  // count step and direction per event action
  logic step;
  logic down;
  always_comb
  begin
    step = running && tick_en;
    down = dir_q;
    if (ev_en)
    begin
      case (event_action_select)
        tmr_pkg::rising_edge_action: step = rise; // [R4]
        tmr_pkg::both_edge_action: step = rise || fall; // [R4]
        tmr_pkg::level_gated_action: step = tick_en && evt; // [R5]
        tmr_pkg::direction_by_event_action:
        begin
          step = tick_en;
          down = evt; // [R6] [R7]
        end
        default: step = 1'b0;
      endcase
    end
  end

  wire freq = (wave_q == tmr_pkg::frequency_waveform);
  // frequency mode borrows channel 0 as its limit
  wire [15:0] limit = freq ? cmp_q[0] : top_q; // [R19]
  wire at_top = !down && (cnt_q == limit);
  wire at_bot = down && (cnt_q == 16'h0000);
  wire single = (wave_q == tmr_pkg::tmr_wave_single);
  // single slope counts up, so the wrap from the limit is its bottom point
  wire top_evt = at_top && !single;
  wire bot_evt = at_bot || (single && at_top);
  wire ovf_ev = step && (top_evt || bot_evt); // [R13]
  wire upd_cond = step && (single ? bot_evt : top_evt); // [R22]
  wire upd_cmd = reg_wr && sel_cmd && reg_wdata[`TMR_BIT_UPD_CMD];
  // lock only holds back the hardware update, never the command
  wire do_upd = (upd_cond && !lock_q) || upd_cmd; // [R20]
  wire [15:0] cnt_inc = cnt_q + 16'h0001;
  wire [15:0] cnt_dec = cnt_q - 16'h0001;
  wire [15:0] cnt_step = down ? cnt_dec : cnt_inc;
  wire [15:0] cnt_next = at_top ? 16'h0000 : (at_bot ? limit : cnt_step);
  wire [15:0] wr16 = {reg_wdata, stage_q}; // [R23]

  // counter with 16-bit commit on the high byte
  // a register write outranks a count step in the same cycle
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_q <= `TMR_RST_ZERO;
    else if (wr_hi && sel_cnt_hi)
      cnt_q <= wr16; // [R18] [R23]
    else if (step)
      cnt_q <= cnt_next;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
    begin
      top_q <= `TMR_RST_TOP; // [R19]
      limsh_q <= `TMR_RST_TOP;
    end
    else
    begin
      if (wr_hi && sel_limsh_hi)
        limsh_q <= wr16;
      if (wr_hi && sel_top_hi)
        top_q <= wr16;
      else if (do_upd && valid_q[`TMR_BIT_LIM_VALID])
        top_q <= limsh_q;
    end

  // per-channel compare registers, shadows and match flags
  logic [NCMP-1:0] cmp_hit;
  logic [NCMP-1:0] csh_wr;
  genvar g;
  generate
    for (g = 0; g < NCMP; g++)
    begin : g_ch
      assign csh_wr[g] = wr_hi && hit(reg_addr, `TMR_OFS_CMPSH + 8'(2 * g + 1));
      assign cmp_hit[g] = (cnt_q == cmp_q[g]); // [R11]
      assign irq_cmp[g] = flag_q[`TMR_BIT_CMP_IRQ - 3 + g] && inten_q[`TMR_BIT_CMP_IRQ + g]; // [R9] [R24]
      always_ff @(posedge clk_sys or posedge sys_rst)
        if (sys_rst)
        begin
          cmp_q[g] <= `TMR_RST_ZERO;
          cmpsh_q[g] <= `TMR_RST_ZERO;
        end
        else
        begin
          if (csh_wr[g])
            cmpsh_q[g] <= wr16;
          if (wr_hi && hit(reg_addr, `TMR_OFS_CMP + 8'(2 * g + 1)))
            cmp_q[g] <= wr16;
          else if (do_upd)
            cmp_q[g] <= cmpsh_q[g]; // [R21]
        end
    end
  endgenerate
  assign cmp_match = cmp_hit;
  // requests are plain levels; no edge logic on this side
  assign irq_ovf = flag_q[`TMR_BIT_OVF] && inten_q[`TMR_BIT_OVF]; // [R10] [R24]

  // valid flags: bit 0 limit, bits 1.. compare; set beats clear
  wire [NCMP:0] v_set_wr = (reg_wr && sel_vfset) ? reg_wdata[NCMP:0] : '0; // [R3]
  wire [NCMP:0] v_clr_wr = (reg_wr && sel_vfclr) ? reg_wdata[NCMP:0] : '0;
  wire lsh_wr = wr_hi && sel_limsh_hi;
  wire [NCMP:0] v_set = v_set_wr | {csh_wr, lsh_wr}; // [R1] [R2]
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      valid_q <= '0;
    else
      valid_q <= ((do_upd ? '0 : valid_q) & ~v_clr_wr) | v_set; // [R1] [R2]
  end

  // interrupt flags: flag index 0 overflow, 1.. compare; write one clears
  wire [NCMP:0] f_set = {cmp_hit & {NCMP{running}}, ovf_ev}; // [R11] [R13]
  wire flag_wr = reg_wr && sel_intflg;
  wire [NCMP:0] f_clr = flag_wr ? {reg_wdata[`TMR_BIT_CMP_IRQ +: NCMP], reg_wdata[`TMR_BIT_OVF]} : '0;
  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      flag_q <= '0;
    else
      flag_q <= (flag_q & ~f_clr) | f_set; // [R12] [R14]
  end

  // plain control registers
  wire [7:0] wave_byte = {5'h00, wave_q};
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
    begin
      event_control_q <= 8'h00;
      inten_q <= 8'h00;
      run_halt_q <= 1'b0;
      wave_q <= 3'h0;
      lock_q <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (sel_event_control)
        event_control_q <= reg_wdata & 8'h0f;
      if (sel_inten)
        inten_q <= reg_wdata & 8'h71;
      if (sel_dbg)
        run_halt_q <= reg_wdata[`TMR_BIT_RUN_HALT];
      if (sel_wave)
        wave_q <= reg_wdata[2:0];
      if (sel_cmd)
        lock_q <= reg_wdata[`TMR_BIT_LOCK];
    end

  // direction latched on a step only
  // kept between steps, so other actions reuse the last direction
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      dir_q <= 1'b0;
    else if (step)
      dir_q <= down; // [R7]
  end

  // 16-bit read source for high-byte capture
  logic [15:0] rd16;
  logic rd16_ok;
  always_comb
  begin
    rd16 = 16'h0000;
    rd16_ok = 1'b1;
    case ({reg_addr[7:1], 1'b0})
      `TMR_OFS_CNT: rd16 = cnt_q;
      `TMR_OFS_TOP: rd16 = top_q;
      `TMR_OFS_LIMSH: rd16 = limsh_q;
      `TMR_OFS_CMP: rd16 = cmp_q[0];
      `TMR_OFS_CMP + 8'h02: rd16 = cmp_q[1];
      `TMR_OFS_CMP + 8'h04: rd16 = cmp_q[2];
      `TMR_OFS_CMPSH: rd16 = cmpsh_q[0];
      `TMR_OFS_CMPSH + 8'h02: rd16 = cmpsh_q[1];
      `TMR_OFS_CMPSH + 8'h04: rd16 = cmpsh_q[2];
      default: rd16_ok = 1'b0;
    endcase
  end

  // staging byte: low write stores, low read captures high
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      stage_q <= 8'h00;
    else if (reg_wr && (sel_stage || (rd16_ok && !reg_addr[0])))
      stage_q <= reg_wdata; // [R17] [R23]
    else if (reg_rd && rd16_ok && !reg_addr[0])
      stage_q <= rd16[15:8]; // [R23]
  end

  // read mux; high byte read returns staged value, unmapped reads zero
  // both bytes of a pair thus come from one instant
  logic [7:0] rmux;
  always_comb
  begin
    rmux = 8'h00;
    if (rd16_ok)
      rmux = reg_addr[0] ? stage_q : rd16[7:0]; // [R18]
    else
    begin
      case (reg_addr)
        `TMR_OFS_VFSET: rmux = {{(7 - NCMP){1'b0}}, valid_q};
        `TMR_OFS_VFCLR: rmux = {{(7 - NCMP){1'b0}}, valid_q};
        `TMR_OFS_EVENT_CONTROL: rmux = event_control_q;
        `TMR_OFS_INTEN: rmux = inten_q;
        `TMR_OFS_INTFLG: rmux = {1'b0, flag_q[NCMP:1], 3'h0, flag_q[0]};
        `TMR_OFS_DBG: rmux = {7'h00, run_halt_q};
        `TMR_OFS_STAGE: rmux = stage_q; // [R17]
        `TMR_OFS_WAVE: rmux = wave_byte;
        `TMR_OFS_CMD: rmux = {6'h00, lock_q, dir_q};
        default: rmux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_q <= 8'h00;
    else if (reg_rd)
      rdata_q <= rmux;
  end
  assign reg_rdata = rdata_q;
endmodule

// >>> core/tmr_defines.svh
// Purpose: offsets, field positions, reset values for the timer register block
// Assumes: byte-wide register port, 8-bit address
// Notes: 16-bit registers take two byte addresses, low byte first
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH
`define TMR_OFS_VFSET 8'h07
`define TMR_OFS_VFCLR 8'h06
`define TMR_OFS_EVENT_CONTROL 8'h09
`define TMR_OFS_INTEN 8'h0a
`define TMR_OFS_INTFLG 8'h0b
`define TMR_OFS_DBG 8'h0e
`define TMR_OFS_STAGE 8'h0f
`define TMR_OFS_CNT 8'h20
`define TMR_OFS_TOP 8'h26
`define TMR_OFS_CMP 8'h28
`define TMR_OFS_LIMSH 8'h36
`define TMR_OFS_CMPSH 8'h38
`define TMR_OFS_WAVE 8'h00
`define TMR_OFS_CMD 8'h05
`define TMR_BIT_LIM_VALID 0
`define TMR_BIT_CMP_VALID 1
`define TMR_BIT_EV_EN 0
`define TMR_BIT_EVENT_ACTION_SELECT_LO 1
`define TMR_BIT_OVF 0
`define TMR_BIT_CMP_IRQ 4
`define TMR_BIT_RUN_HALT 0
`define TMR_BIT_LOCK 1
`define TMR_BIT_UPD_CMD 2
`define TMR_RST_TOP 16'hffff
`define TMR_RST_ZERO 16'h0000
`endif

// >>> core/tmr_pkg.sv
// Purpose: types for the timer register block
// Assumes: nothing
// Notes: event action codes follow the register field encoding
package tmr_pkg;
  typedef enum logic [2:0] {
    rising_edge_action = 3'h0,
    both_edge_action = 3'h1,
    level_gated_action = 3'h2,
    direction_by_event_action = 3'h3
  } tmr_event_action_select_t;
  typedef enum logic [2:0] {
    tmr_wave_normal = 3'h0,
    frequency_waveform = 3'h1,
    tmr_wave_single = 3'h3
  } tmr_wave_t;
endpackage

// >>> verification/tmr_core_props.sv
// Purpose: port-level checks for the timer register block
// Assumes: offsets as in tmr_defines.svh
// Notes: flags are hidden, so checks lean on their write causes
`timescale 1ns/1ps
module tmr_core_props #(
  parameter int NCMP = 3
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic tick_en,
  input wire logic evt_in,
  input wire logic dbg_halt,
  input wire logic irq_ovf,
  input wire logic [NCMP-1:0] irq_cmp,
  input wire logic [NCMP-1:0] cmp_match
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // only enable or flag writes may drop a request
  wire irq_wr = reg_wr && (reg_addr == 8'h0a || reg_addr == 8'h0b);
  a_cmp_req_sticky: assert property (irq_cmp[0] && !irq_wr |=> irq_cmp[0])
    else $error("compare request dropped without a write");
  a_ovf_req_sticky: assert property (irq_ovf && !irq_wr |=> irq_ovf)
    else $error("overflow request dropped without a write");
  a_cmp_irq_cause: assert property ($rose(irq_cmp[0]) |-> $past(cmp_match[0] || irq_wr))
    else $error("compare request rose without match or enable");
  a_cmp_clear_works: assert property (reg_wr && reg_addr == 8'h0b && reg_wdata[4] && !cmp_match[0]
    |=> !irq_cmp[0])
    else $error("compare flag not cleared by write one");
  a_stage_readback: assert property (reg_wr && reg_addr == 8'h0f ##1 reg_rd && reg_addr == 8'h0f
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("staging byte readback wrong");
  a_cnt_commit_read: assert property (reg_wr && reg_addr == 8'h20 ##1 reg_wr && reg_addr == 8'h21 && !tick_en
    ##1 reg_rd && reg_addr == 8'h20 && !tick_en |=> reg_rdata == $past(reg_wdata, 3))
    else $error("counter low byte lost after 16-bit write");
  a_inten_reserved_zero: assert property (reg_rd && reg_addr == 8'h0a
    |=> reg_rdata[3:1] == 3'h0 && !reg_rdata[7])
    else $error("reserved enable bits read nonzero");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !irq_ovf && irq_cmp == '0)
    else $error("request active right after reset");
  c_ovf_req: cover property ($rose(irq_ovf));
  c_cmp_req: cover property ($rose(irq_cmp[0]));
  c_update_cmd: cover property (reg_wr && reg_addr == 8'h05 && reg_wdata[2]);
endmodule
bind tmr_core tmr_core_props #(.NCMP(NCMP)) i_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tick_en(tick_en), .evt_in(evt_in), .dbg_halt(dbg_halt), .irq_ovf(irq_ovf), .irq_cmp(irq_cmp),
  .cmp_match(cmp_match));

// >>> verification/tmr_core_tb.sv
// Purpose: self-checking bench for the timer register block
// Assumes: bench drives ticks and events itself
// Notes: edge-count actions are taken to ignore ticks
`timescale 1ns/1ps
module tmr_core_tb;
  logic clk_sys, sys_rst, reg_wr, reg_rd, tick_en, evt_in, dbg_halt, irq_ovf;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] irq_cmp, cmp_match;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] lfsr = 32'h1095;
  logic [15:0] v;
  int ev_delta[4] = '{1, 2, 2, -1};
  logic [7:0] ra[10] = '{8'h07, 8'h09, 8'h0a, 8'h0b, 8'h0e, 8'h0f, 8'h20, 8'h21, 8'h26, 8'h27};
  logic [7:0] rv[10] = '{8'h00, 8'h00, 8'h00, 8'h70, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};
  tmr_core i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tick_en(tick_en), .evt_in(evt_in),
    .dbg_halt(dbg_halt), .irq_ovf(irq_ovf), .irq_cmp(irq_cmp), .cmp_match(cmp_match));
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // strobe stays up so writes can run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk($sformatf("reg %h", a), reg_rdata, exp);
    @(posedge clk_sys);
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 8'h01, d[15:8]);
  endtask
  task automatic rd16(input logic [7:0] a, input logic [15:0] d);
    rd(a, d[7:0]);
    rd(a + 8'h01, d[15:8]);
  endtask
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic tick(input int n);
    idle(1);
    repeat (n)
    begin
      tick_en <= 1'b1;
      @(posedge clk_sys);
      tick_en <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  // hang guard, run needs a few hundred cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    tick_en = 1'b0;
    evt_in = 1'b0;
    dbg_halt = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 10; i++)
      rd(ra[i], rv[i]);
    lfsr = lfsr_next(lfsr);
    wr(8'h0f, lfsr[7:0]);
    rd(8'h0f, lfsr[7:0]);
    wr(8'h07, 8'h05);
    wr(8'h07, 8'h00);
    rd(8'h07, 8'h05);
    wr(8'h06, 8'h0f);
    v = lfsr[23:8] | 16'h0100;
    wr16(8'h38, v);
    wr16(8'h36, 16'hffff);
    rd(8'h07, 8'h03);
    wr(8'h05, 8'h06);
    rd(8'h07, 8'h00);
    rd16(8'h28, v);
    wr16(8'h20, v);
    wr(8'h0a, 8'h10);
    idle(2);
    @(negedge clk_sys);
    chk("cmp_match", {5'h0, cmp_match}, 8'h01);
    chk("irq_cmp", {5'h0, irq_cmp}, 8'h01);
    @(posedge clk_sys);
    wr16(8'h20, v - 16'h0001);
    rd16(8'h20, v - 16'h0001);
    chk("irq_cmp held", {5'h0, irq_cmp}, 8'h01);
    wr(8'h0b, 8'h70);
    rd(8'h0b, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h09, 8'(c * 2 + 1));
      wr16(8'h20, 16'h0100);
      evt_in <= 1'b1;
      idle(5);
      tick(2);
      evt_in <= 1'b0;
      idle(5);
      tick(1);
      idle(5);
      rd16(8'h20, 16'(256 + ev_delta[c]));
    end
    wr(8'h09, 8'h00);
    wr16(8'h26, 16'h0005);
    wr16(8'h20, 16'h0000);
    wr(8'h0b, 8'h71);
    tick(6);
    @(negedge clk_sys);
    chk("irq_ovf off", {7'h0, irq_ovf}, 8'h00);
    @(posedge clk_sys);
    rd(8'h0b, 8'h61);
    wr(8'h0a, 8'h01);
    idle(1);
    @(negedge clk_sys);
    chk("irq_ovf on", {7'h0, irq_ovf}, 8'h01);
    @(posedge clk_sys);
    wr(8'h0b, 8'h01);
    rd(8'h0b, 8'h60);
    wr(8'h00, 8'h03);
    wr(8'h0b, 8'h71);
    tick(6);
    rd(8'h0b, 8'h61);
    wr(8'h00, 8'h01);
    wr16(8'h28, 16'h0003);
    wr(8'h0b, 8'h71);
    tick(4);
    rd(8'h0b, 8'h71);
    rd16(8'h28, 16'h0003);
    wr(8'h05, 8'h00);
    tick(4);
    rd16(8'h28, v);
    wr(8'h00, 8'h00);
    dbg_halt <= 1'b1;
    idle(4);
    tick(3);
    rd16(8'h20, 16'h0000);
    wr(8'h0e, 8'h01);
    tick(3);
    rd16(8'h20, 16'h0003);
    rd(8'h10, 8'h00);
    tally_and_finish();
  end
endmodule
